/* File: rg3_regs.sv */
// The AXI4-Lite slave port is this design's own decision.
`default_nettype none
module rg3_regs
    import rg3_pkg::*;
#(
    parameter logic [15:0] CTRL_DEFAULT = CTRL_DEF,
    parameter logic [15:0] SEQ_DEFAULT  = SEQ_DEF,
    parameter logic [15:0] LP_DEFAULT   = LP_DEF
)
(
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic [ADDR_W-1:0] s_axil_awaddr,
    input  wire logic              s_axil_awvalid,
    output logic                   s_axil_awready,
    input  wire logic [31:0]       s_axil_wdata,
    input  wire logic [3:0]        s_axil_wstrb,
    input  wire logic              s_axil_wvalid,
    output logic                   s_axil_wready,
    output logic [1:0]             s_axil_bresp,
    output logic                   s_axil_bvalid,
    input  wire logic              s_axil_bready,
    input  wire logic [ADDR_W-1:0] s_axil_araddr,
    input  wire logic              s_axil_arvalid,
    output logic                   s_axil_arready,
    output logic [31:0]            s_axil_rdata,
    output logic [1:0]             s_axil_rresp,
    output logic                   s_axil_rvalid,
    input  wire logic              s_axil_rready,
    input  wire logic              psm_restore,
    input  wire logic              startup_slot_pulse,
    input  wire logic              shutdown_slot_pulse,
    input  wire logic [3:0]        slot_number,
    input  wire logic              enter_active,
    input  wire logic              enter_off,
    input  wire logic              regulator_fault,
    input  wire logic              hibernate_reg_bit,
    input  wire logic              low_power_input_one,
    input  wire logic              low_power_input_two,
    input  wire logic              low_power_input_three,
    input  wire logic              others_all_disabled,
    output logic                   regulator_enable,
    output logic                   switch_mode_select,
    output logic                   discharge_enable,
    output logic [4:0]             applied_voltage_code,
    output logic [11:0]            applied_voltage_mv,
    output logic                   hibernating,
    output logic                   fault_irq,
    output logic                   system_shutdown_req
);
    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    logic [15:0] ctrl_reg;
    logic [15:0] ctrl_next;
    logic [15:0] seq_reg;
    logic [15:0] seq_next;
    logic [15:0] lp_reg;
    logic [15:0] lp_next;
    logic        fault_seen_reg;
    logic        fault_seen_next;
    rg3_state_t  state_reg;
    rg3_state_t  state_next;
    logic        irq_reg;
    logic        sys_sd_reg;
    logic        out_on_reg;
    logic        swi_reg;
    logic        dis_reg;
    logic [4:0]  code_reg;
    logic [11:0] mv_reg;
    logic        hib_reg;

    rg3_regbus_if rb ();

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    rg3_axil_slave u_slave (
        .clk            (clk),
        .srst           (srst),
        .s_axil_awaddr  (s_axil_awaddr),
        .s_axil_awvalid (s_axil_awvalid),
        .s_axil_awready (s_axil_awready),
        .s_axil_wdata   (s_axil_wdata),
        .s_axil_wstrb   (s_axil_wstrb),
        .s_axil_wvalid  (s_axil_wvalid),
        .s_axil_wready  (s_axil_wready),
        .s_axil_bresp   (s_axil_bresp),
        .s_axil_bvalid  (s_axil_bvalid),
        .s_axil_bready  (s_axil_bready),
        .s_axil_araddr  (s_axil_araddr),
        .s_axil_arvalid (s_axil_arvalid),
        .s_axil_arready (s_axil_arready),
        .s_axil_rdata   (s_axil_rdata),
        .s_axil_rresp   (s_axil_rresp),
        .s_axil_rvalid  (s_axil_rvalid),
        .s_axil_rready  (s_axil_rready),
        .rb             (rb)
    );

    // ----------------------------------------------------------------
    // Address decode and byte-lane merge
    // ----------------------------------------------------------------
    function automatic logic [15:0] merge(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [1:0]  strb,
                                          input logic [15:0] mask);
        logic [15:0] lanes;
        lanes = {{8{strb[1]}}, {8{strb[0]}}} & mask;
        merge = (old_v & ~lanes) | (new_v & lanes);
    endfunction

    wire hit_ctrl_w = rb.wr_en && (rb.wr_idx == CTRL_IDX);
    wire hit_seq_w  = rb.wr_en && (rb.wr_idx == SEQ_IDX);
    wire hit_lp_w   = rb.wr_en && (rb.wr_idx == LP_IDX);
    wire hit_stat_w = rb.wr_en && (rb.wr_idx == STAT_IDX);
    wire flt_clear  = hit_stat_w && rb.wr_strb[0] && rb.wr_data[ST_FLT_BIT];
    wire reload     = psm_restore;

    assign rb.wr_hit = (rb.wr_idx == CTRL_IDX) || (rb.wr_idx == SEQ_IDX) ||
                       (rb.wr_idx == LP_IDX) || (rb.wr_idx == STAT_IDX);
    assign rb.rd_hit = (rb.rd_idx == CTRL_IDX) || (rb.rd_idx == SEQ_IDX) ||
                       (rb.rd_idx == LP_IDX) || (rb.rd_idx == STAT_IDX);

    wire [15:0] stat_word = {12'h000, fault_seen_reg, dis_reg, hib_reg, out_on_reg};
    assign rb.rd_data = (rb.rd_idx == CTRL_IDX) ? ctrl_reg :
                        (rb.rd_idx == SEQ_IDX)  ? seq_reg  :
                        (rb.rd_idx == LP_IDX)   ? lp_reg   :
                        (rb.rd_idx == STAT_IDX) ? stat_word : 16'h0000;

    // ----------------------------------------------------------------
    // Field views
    // ----------------------------------------------------------------
    wire [1:0] fault_act  = seq_reg[FACT_LSB +: 2];
    wire [3:0] en_slot    = seq_reg[EN_LSB +: SLOT_W];
    wire [3:0] sd_slot    = seq_reg[SD_LSB +: SLOT_W];
    wire [1:0] hib_src    = lp_reg[HSRC_LSB +: 2];

    // Hibernate trigger selection
    wire hib_trig = (hib_src == HS_REGBIT) ? hibernate_reg_bit   :
                    (hib_src == HS_LP1)    ? low_power_input_one :
                    (hib_src == HS_LP2)    ? low_power_input_two :
                                             low_power_input_three;

    // Start-up: slots 1..14 on matching strobe, code 15 on active entry
    wire en_slot_ok = (en_slot != SLOT_NONE) && (en_slot != SLOT_ACTIVE);
    wire start_hit  = (startup_slot_pulse && en_slot_ok &&
                       (slot_number == en_slot)) ||
                      (enter_active && (en_slot == SLOT_ACTIVE));

    // Shutdown: slots 1..14 on matching strobe, any slot code at off entry
    wire sd_slot_ok = (sd_slot != SLOT_NONE) && (sd_slot != SLOT_ACTIVE);
    wire stop_hit   = (shutdown_slot_pulse && sd_slot_ok &&
                       (slot_number == sd_slot)) ||
                      enter_off;

    // Fault reaction
    wire fault_kill   = regulator_fault && (fault_act == FA_REG);
    wire fault_system = regulator_fault && (fault_act != FA_IGNORE) &&
                        (fault_act != FA_REG);

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        ctrl_next = hit_ctrl_w ? merge(ctrl_reg, rb.wr_data, rb.wr_strb, CTRL_MASK)
                               : ctrl_reg;
        seq_next  = hit_seq_w ? merge(seq_reg, rb.wr_data, rb.wr_strb, SEQ_MASK)
                              : seq_reg;
        lp_next   = hit_lp_w ? merge(lp_reg, rb.wr_data, rb.wr_strb, LP_MASK)
                             : lp_reg;
        if (reload) begin
            ctrl_next = CTRL_DEFAULT & CTRL_MASK;
            seq_next  = SEQ_DEFAULT & SEQ_MASK;
            lp_next   = LP_DEFAULT & LP_MASK;
        end
        // Set beats the clear in the same cycle
        fault_seen_next = regulator_fault || (fault_seen_reg && !flt_clear);
    end

    // Enable state sequencing
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            RG3_OFF: begin
                if (start_hit && !fault_kill && !enter_off)
                    state_next = RG3_ON;
            end
            RG3_ON: begin
                if (stop_hit || fault_kill || reload)
                    state_next = RG3_OFF;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Output decode
    // ----------------------------------------------------------------
    wire        dec_on;
    wire        dec_swi;
    wire        dec_dis;
    wire [4:0]  dec_code;
    wire [11:0] dec_mv;

    rg3_out_decode u_decode (
        .ctrl           (ctrl_reg),
        .lp             (lp_reg),
        .enabled        (state_reg == RG3_ON),
        .hib_active     (hib_trig),
        .others_all_off (others_all_disabled),
        .output_on      (dec_on),
        .switch_mode    (dec_swi),
        .discharge_on   (dec_dis),
        .eff_code       (dec_code),
        .eff_mv         (dec_mv)
    );

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_reg       <= CTRL_DEFAULT & CTRL_MASK;
            seq_reg        <= SEQ_DEFAULT & SEQ_MASK;
            lp_reg         <= LP_DEFAULT & LP_MASK;
            fault_seen_reg <= 1'b0;
            state_reg      <= RG3_OFF;
        end else begin
            ctrl_reg       <= ctrl_next;
            seq_reg        <= seq_next;
            lp_reg         <= lp_next;
            fault_seen_reg <= fault_seen_next;
            state_reg      <= state_next;
        end
    end

    // Registered outputs and event pulses
    always_ff @(posedge clk) begin
        if (srst) begin
            irq_reg    <= 1'b0;
            sys_sd_reg <= 1'b0;
            out_on_reg <= 1'b0;
            swi_reg    <= 1'b0;
            dis_reg    <= 1'b1;
            code_reg   <= 5'h00;
            mv_reg     <= 12'h000;
            hib_reg    <= 1'b0;
        end else begin
            irq_reg    <= regulator_fault;
            sys_sd_reg <= fault_system;
            out_on_reg <= dec_on;
            swi_reg    <= dec_swi;
            dis_reg    <= dec_dis;
            code_reg   <= dec_code;
            mv_reg     <= dec_mv;
            hib_reg    <= hib_trig;
        end
    end

    assign regulator_enable     = out_on_reg;
    assign switch_mode_select   = swi_reg;
    assign discharge_enable     = dis_reg;
    assign applied_voltage_code = code_reg;
    assign applied_voltage_mv   = mv_reg;
    assign hibernating          = hib_reg;
    assign fault_irq            = irq_reg;
    assign system_shutdown_req  = sys_sd_reg;
endmodule // rg3_regs
`default_nettype wire

/* File: rg3_pkg.sv */
`default_nettype none
package rg3_pkg;
    // ----------------------------------------------------------------
    // Register map (index and byte address)
    // ----------------------------------------------------------------
    localparam int          ADDR_W      = 12;
    localparam logic [7:0]  CTRL_IDX    = 8'hce;
    localparam logic [7:0]  SEQ_IDX     = 8'hcf;
    localparam logic [7:0]  LP_IDX      = 8'hd0;
    localparam logic [7:0]  STAT_IDX    = 8'hd8;
    localparam logic [11:0] CTRL_ADDR   = {2'h0, CTRL_IDX, 2'h0};
    localparam logic [11:0] SEQ_ADDR    = {2'h0, SEQ_IDX, 2'h0};
    localparam logic [11:0] LP_ADDR     = {2'h0, LP_IDX, 2'h0};
    localparam logic [11:0] STAT_ADDR   = {2'h0, STAT_IDX, 2'h0};

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int SWI_BIT     = 14;
    localparam int OPFLT_BIT   = 10;
    localparam int VSEL_LSB    = 0;
    localparam int VCODE_W     = 5;
    localparam int FACT_LSB    = 14;
    localparam int EN_LSB      = 10;
    localparam int SD_LSB      = 6;
    localparam int SLOT_W      = 4;
    localparam int HMODE_LSB   = 12;
    localparam int HSRC_LSB    = 8;
    localparam int VIMG_LSB    = 0;
    localparam int ST_ON_BIT   = 0;
    localparam int ST_HIB_BIT  = 1;
    localparam int ST_DIS_BIT  = 2;
    localparam int ST_FLT_BIT  = 3;

    // ----------------------------------------------------------------
    // Writable masks and mask-option defaults
    // ----------------------------------------------------------------
    localparam logic [15:0] CTRL_MASK = 16'h441f;
    localparam logic [15:0] SEQ_MASK  = 16'hffc0;
    localparam logic [15:0] LP_MASK   = 16'h331f;
    localparam logic [15:0] CTRL_DEF  = 16'h001b;
    localparam logic [15:0] SEQ_DEF   = 16'h0000;
    localparam logic [15:0] LP_DEF    = 16'h001c;

    // ----------------------------------------------------------------
    // Codes
    // ----------------------------------------------------------------
    localparam logic [3:0]  SLOT_NONE   = 4'h0;
    localparam logic [3:0]  SLOT_ACTIVE = 4'hf;
    localparam logic [1:0]  FA_IGNORE   = 2'h0;
    localparam logic [1:0]  FA_REG      = 2'h1;
    localparam logic [1:0]  HB_IMAGE    = 2'h0;
    localparam logic [1:0]  HB_DISABLE  = 2'h1;
    localparam logic [1:0]  HS_REGBIT   = 2'h0;
    localparam logic [1:0]  HS_LP1      = 2'h1;
    localparam logic [1:0]  HS_LP2      = 2'h2;
    localparam logic [11:0] V_LOW_MV    = 12'd900;
    localparam logic [11:0] V_LOW_STEP  = 12'd50;
    localparam logic [11:0] V_HIGH_MV   = 12'd1800;
    localparam logic [11:0] V_HIGH_STEP = 12'd100;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef enum logic {RG3_OFF, RG3_ON} rg3_state_t;
endpackage
`default_nettype wire

/* File: rg3_regbus_if.sv */
`default_nettype none
interface rg3_regbus_if;
    logic        wr_en;
    logic [7:0]  wr_idx;
    logic [15:0] wr_data;
    logic [1:0]  wr_strb;
    logic        wr_hit;
    logic [7:0]  rd_idx;
    logic [15:0] rd_data;
    logic        rd_hit;
    modport slave (output wr_en, wr_idx, wr_data, wr_strb, rd_idx,
                   input  wr_hit, rd_data, rd_hit);
    modport core  (input  wr_en, wr_idx, wr_data, wr_strb, rd_idx,
                   output wr_hit, rd_data, rd_hit);
endinterface
`default_nettype wire

/* File: rg3_axil_slave.sv */
`default_nettype none
module rg3_axil_slave
    import rg3_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic [ADDR_W-1:0] s_axil_awaddr,
    input  wire logic              s_axil_awvalid,
    output logic                   s_axil_awready,
    input  wire logic [31:0]       s_axil_wdata,
    input  wire logic [3:0]        s_axil_wstrb,
    input  wire logic              s_axil_wvalid,
    output logic                   s_axil_wready,
    output logic [1:0]             s_axil_bresp,
    output logic                   s_axil_bvalid,
    input  wire logic              s_axil_bready,
    input  wire logic [ADDR_W-1:0] s_axil_araddr,
    input  wire logic              s_axil_arvalid,
    output logic                   s_axil_arready,
    output logic [31:0]            s_axil_rdata,
    output logic [1:0]             s_axil_rresp,
    output logic                   s_axil_rvalid,
    input  wire logic              s_axil_rready,
    rg3_regbus_if.slave            rb
);
    logic              aw_held_reg;
    logic              w_held_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [15:0]       wdata_reg;
    logic [1:0]        wstrb_reg;
    logic              bvalid_reg;
    logic [1:0]        bresp_reg;
    logic              rvalid_reg;
    logic [1:0]        rresp_reg;
    logic [15:0]       rdata_reg;
    wire               wr_fire;
    wire               rd_fire;
    wire               aw_top_ok;
    wire               ar_top_ok;

    // Handshake readies and register-port decode
    assign s_axil_awready = !aw_held_reg && !bvalid_reg;
    assign s_axil_wready  = !w_held_reg && !bvalid_reg;
    assign s_axil_arready = !rvalid_reg;
    assign wr_fire        = aw_held_reg && w_held_reg && !bvalid_reg;
    assign rd_fire        = s_axil_arvalid && !rvalid_reg;
    assign aw_top_ok      = (awaddr_reg[ADDR_W-1:10] == 2'h0);
    assign ar_top_ok      = (s_axil_araddr[ADDR_W-1:10] == 2'h0);
    assign rb.wr_en       = wr_fire && aw_top_ok;
    assign rb.wr_idx      = awaddr_reg[9:2];
    assign rb.wr_data     = wdata_reg;
    assign rb.wr_strb     = wstrb_reg;
    assign rb.rd_idx      = s_axil_araddr[9:2];
    assign s_axil_bvalid  = bvalid_reg;
    assign s_axil_bresp   = bresp_reg;
    assign s_axil_rvalid  = rvalid_reg;
    assign s_axil_rresp   = rresp_reg;
    assign s_axil_rdata   = {16'h0000, rdata_reg};

    // Write channel capture in either order, then response
    always_ff @(posedge clk) begin
        if (srst) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            awaddr_reg  <= '0;
            wdata_reg   <= 16'h0000;
            wstrb_reg   <= 2'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
        end else begin
            if (s_axil_awvalid && s_axil_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_axil_awaddr;
            end
            if (s_axil_wvalid && s_axil_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axil_wdata[15:0];
                wstrb_reg  <= s_axil_wstrb[1:0];
            end
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= (aw_top_ok && rb.wr_hit) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_reg && s_axil_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // Read channel: data sampled at address acceptance
    always_ff @(posedge clk) begin
        if (srst) begin
            rvalid_reg <= 1'b0;
            rresp_reg  <= RESP_OKAY;
            rdata_reg  <= 16'h0000;
        end else if (rd_fire) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= (ar_top_ok && rb.rd_hit) ? RESP_OKAY : RESP_SLVERR;
            rdata_reg  <= (ar_top_ok && rb.rd_hit) ? rb.rd_data : 16'h0000;
        end else if (rvalid_reg && s_axil_rready) begin
            rvalid_reg <= 1'b0;
        end
    end
endmodule // rg3_axil_slave
`default_nettype wire

/* File: rg3_out_decode.sv */
`default_nettype none
module rg3_out_decode
    import rg3_pkg::*;
(
    input  wire logic [15:0]        ctrl,
    input  wire logic [15:0]        lp,
    input  wire logic               enabled,
    input  wire logic               hib_active,
    input  wire logic               others_all_off,
    output logic                    output_on,
    output logic                    switch_mode,
    output logic                    discharge_on,
    output logic [VCODE_W-1:0]      eff_code,
    output logic [11:0]             eff_mv
);
    // Two-range voltage code to millivolts
    function automatic logic [11:0] code_to_mv(input logic [VCODE_W-1:0] c);
        logic [11:0] low;
        low = {8'h00, c[3:0]};
        if (c[VCODE_W-1])
            code_to_mv = V_HIGH_MV + 12'(V_HIGH_STEP * low);
        else
            code_to_mv = V_LOW_MV + 12'(V_LOW_STEP * low);
    endfunction

    wire [1:0] hib_mode   = lp[HMODE_LSB +: 2];
    wire       use_image  = hib_active && (hib_mode == HB_IMAGE);
    wire       hib_off    = hib_active && (hib_mode == HB_DISABLE);
    wire       floats_sel = ctrl[OPFLT_BIT];

    // Effective output state
    assign output_on    = enabled && !hib_off;
    assign switch_mode  = ctrl[SWI_BIT];
    assign discharge_on = !output_on && (!floats_sel || others_all_off);
    assign eff_code     = use_image ? lp[VIMG_LSB +: VCODE_W]
                                    : ctrl[VSEL_LSB +: VCODE_W];
    assign eff_mv       = switch_mode ? 12'h000 : code_to_mv(eff_code);
endmodule // rg3_out_decode
`default_nettype wire

/* File: rg3_regs_checker.sv */
`default_nettype none
module rg3_regs_checker
    import rg3_pkg::*;
(
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        s_axil_arvalid,
    input wire logic        s_axil_arready,
    input wire logic        s_axil_rvalid,
    input wire logic        s_axil_rready,
    input wire logic [31:0] s_axil_rdata,
    input wire logic        s_axil_bvalid,
    input wire logic        s_axil_bready,
    input wire logic        regulator_fault,
    input wire logic        fault_irq,
    input wire logic        system_shutdown_req,
    input wire logic        switch_mode_select,
    input wire logic        regulator_enable,
    input wire logic        discharge_enable,
    input wire logic [4:0]  applied_voltage_code,
    input wire logic [11:0] applied_voltage_mv
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // Fault and read request events
    sequence fault_seen; regulator_fault; endsequence
    sequence rd_taken; s_axil_arvalid && s_axil_arready; endsequence
    AST_IRQ_PULSE: assert property (fault_seen |=> fault_irq)
        else $error("fault without interrupt");
    AST_IRQ_CAUSE: assert property (!regulator_fault |=> !fault_irq)
        else $error("interrupt without fault");
    AST_SHUT_CAUSE: assert property (system_shutdown_req |-> $past(regulator_fault))
        else $error("shutdown request without fault");
    AST_SWITCH_MV: assert property (switch_mode_select |-> applied_voltage_mv == 12'h0)
        else $error("voltage applied in switch mode");
    AST_VOLT_MAP: assert property (!switch_mode_select && !$past(srst) |->
        applied_voltage_mv == (applied_voltage_code[4] ?
        12'd1800 + 12'd100 * applied_voltage_code[3:0] :
        12'd900 + 12'd50 * applied_voltage_code[3:0])) else $error("wrong millivolts");
    AST_DISCH_OFF: assert property (regulator_enable |-> !discharge_enable)
        else $error("discharge while on");
    AST_RD_ANSWER: assert property (rd_taken |=> s_axil_rvalid)
        else $error("read not answered");
    AST_RD_HOLD: assert property (s_axil_rvalid && !s_axil_rready |=>
        s_axil_rvalid && $stable(s_axil_rdata)) else $error("read data dropped");
    AST_B_HOLD: assert property (s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid)
        else $error("write response dropped");
endmodule // rg3_regs_checker
bind rg3_regs rg3_regs_checker u_chk (.*);
`default_nettype wire

/* File: tb_top.sv */
`default_nettype none
module tb_top import rg3_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, srst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
    logic awr, wrd, bv, arr, rv, sm, en, dis, hib, irq, sd;
    logic [11:0] awa = 0, ara = 0, mv;
    logic [31:0] wd = 0, rdat;
    logic [1:0]  br, rr;
    logic [5:0]  ev = 0;
    logic [4:0]  lv = 0, code;
    logic [3:0]  sl = 0;
    logic [15:0] s = 16'h7b03;
    logic [33:0] q[$];
    int          bad_count = 0, cmp_count = 0, sd_n = 0;
    rg3_regs dut (.clk(clk), .srst(srst), .s_axil_awaddr(awa), .s_axil_awvalid(awv),
        .s_axil_awready(awr), .s_axil_wdata(wd), .s_axil_wstrb(4'hf), .s_axil_wvalid(wv),
        .s_axil_wready(wrd), .s_axil_bresp(br), .s_axil_bvalid(bv), .s_axil_bready(bre),
        .s_axil_araddr(ara), .s_axil_arvalid(arv), .s_axil_arready(arr), .s_axil_rdata(rdat),
        .s_axil_rresp(rr), .s_axil_rvalid(rv), .s_axil_rready(rre), .psm_restore(ev[5]),
        .startup_slot_pulse(ev[0]), .shutdown_slot_pulse(ev[1]), .slot_number(sl),
        .enter_active(ev[2]), .enter_off(ev[3]), .regulator_fault(ev[4]),
        .hibernate_reg_bit(lv[0]), .low_power_input_one(lv[1]), .low_power_input_two(lv[2]),
        .low_power_input_three(lv[3]), .others_all_disabled(lv[4]), .regulator_enable(en),
        .switch_mode_select(sm), .discharge_enable(dis), .applied_voltage_code(code),
        .applied_voltage_mv(mv), .hibernating(hib), .fault_irq(irq), .system_shutdown_req(sd));
    initial forever #10 clk = ~clk;
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic hang;
        bad_count++;
        finish_test;
    endtask
    // Bus write, response code compared
    task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] r);
        bit ok = 0;
        @(posedge clk);
        awa <= a; wd <= {16'h0, d}; awv <= 1; wv <= 1; bre <= 1;
        repeat (40) if (!ok) begin
            @(posedge clk);
            if (awr) awv <= 0;
            if (wrd) wv <= 0;
            if (bv) begin ok = 1; chk("bresp", r, br); end
        end
        bre <= 0;
        if (!ok) hang;
    endtask
    // Bus read, expectation queued for the monitor
    task automatic rd(input logic [11:0] a, input logic [15:0] d, input logic [1:0] r);
        bit ok = 0;
        @(posedge clk);
        q.push_back({r, 16'h0, d}); ara <= a; arv <= 1; rre <= 1;
        repeat (40) if (!ok) begin
            @(posedge clk);
            if (arr) arv <= 0;
            if (rv) ok = 1;
        end
        rre <= 0;
        if (!ok) hang;
    endtask
    always @(posedge clk) if (rv && rre) chk("rdata", q.pop_front(), {rr, rdat});
    // System shutdown pulse counter
    always @(posedge clk) if (sd === 1'b1) sd_n++;
    task automatic w3; repeat (3) @(posedge clk); endtask
    task automatic pl(input int k); @(posedge clk); ev[k] <= 1; @(posedge clk); ev <= 0; w3; endtask
    initial begin
        repeat (16) @(posedge clk);
        srst <= 0;
        rd(CTRL_ADDR, CTRL_DEF, RESP_OKAY);
        rd(SEQ_ADDR, SEQ_DEF, RESP_OKAY);
        rd(LP_ADDR, LP_DEF, RESP_OKAY);
        repeat (4) begin
            s = lfsr(s);
            wr(CTRL_ADDR, s, RESP_OKAY);
            rd(CTRL_ADDR, s & CTRL_MASK, RESP_OKAY);
            chk("swi", s[14], sm);
        end
        wr(12'h344, 16'hffff, RESP_SLVERR);
        rd(12'h344, 16'h0, RESP_SLVERR);
        wr(CTRL_ADDR, 16'h0010, RESP_OKAY);
        wr(SEQ_ADDR, 16'h8d40, RESP_OKAY);
        sl <= 4'h3;
        pl(0); chk("en", 1'b1, en);
        chk("mv", 12'd1800, mv);
        pl(4); chk("sd", 32'd1, sd_n);
        rd(STAT_ADDR, 16'h0009, RESP_OKAY);
        wr(STAT_ADDR, 16'h0008, RESP_OKAY);
        rd(STAT_ADDR, 16'h0001, RESP_OKAY);
        wr(LP_ADDR, 16'h1100, RESP_OKAY);
        lv <= 5'h02; w3; chk("en", 1'b0, en);
        chk("dis", 1'b1, dis);
        chk("hib", 1'b1, hib);
        lv <= 5'h00; w3; chk("en", 1'b1, en);
        wr(LP_ADDR, 16'h1300, RESP_OKAY);
        lv <= 5'h08; w3; chk("hib", 1'b1, hib);
        chk("en", 1'b0, en);
        wr(LP_ADDR, 16'h0205, RESP_OKAY);
        lv <= 5'h04; w3; chk("mv", 12'd1150, mv);
        lv <= 5'h00; sl <= 4'h5;
        pl(1); chk("en", 1'b0, en);
        wr(CTRL_ADDR, 16'h0410, RESP_OKAY);
        w3; chk("dis", 1'b0, dis);
        lv <= 5'h10; w3; chk("dis", 1'b1, dis);
        wr(SEQ_ADDR, 16'h7c00, RESP_OKAY);
        pl(2); chk("en", 1'b1, en);
        pl(3); chk("en", 1'b0, en);
        pl(2); chk("en", 1'b1, en);
        pl(4); chk("en", 1'b0, en);
        chk("sd", 32'd1, sd_n);
        pl(5); rd(CTRL_ADDR, CTRL_DEF, RESP_OKAY);
        finish_test;
    end
endmodule // tb_top
`default_nettype wire
